// File: logic/sfr_read_seq.sv
// Read command sequencer of a serial flash with two page buffers.
// Assumes serial pins synchronous to clock, memory answers each fetch
// within half a serial clock period.
module sfr_read_seq
	import sfr_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        rst,
	input  wire logic        resetN,
	input  wire logic        csN,
	input  wire logic        sck,
	input  wire logic        si,
	input  wire logic        pageIs512,
	output logic             so,
	output logic             soOe,
	output logic             memReq,
	input  wire logic        memGrant,
	output logic [1:0]       memSel,
	output logic [11:0]      memPage,
	output logic [9:0]       memByte,
	input  wire logic        memRdValid,
	input  wire logic [7:0]  memRdData,
	output logic             memRdReady
);

	// ****************************************
	// Decoding
	// ****************************************
	function automatic logic [6:0] hdrOf(input logic [7:0] op);
		case (op)
			OPC_LEGACY, OPC_PAGE: hdrOf = HDR_FOUR;
			OPC_FAST, OPC_BUF1_FAST, OPC_BUF1_SLOW,
			OPC_BUF2_FAST, OPC_BUF2_SLOW: hdrOf = HDR_ONE;
			OPC_SLOW: hdrOf = HDR_NONE;
			default: hdrOf = HDR_BAD;
		endcase
	endfunction : hdrOf

	sfr_state_type state_reg;
	logic        sckPrev_reg;
	logic [6:0]  cnt_reg;
	logic [6:0]  hdrLen_reg;
	logic [23:0] addr_reg;
	logic [1:0]  src_reg;
	logic        samePage_reg;
	logic        fetchEn_reg;
	logic        pend_reg;
	logic [11:0] page_reg;
	logic [9:0]  byte_reg;
	logic [7:0]  fifo_reg [FIFO_DEPTH];
	logic        wrPtr_reg;
	logic        rdPtr_reg;
	logic [1:0]  count_reg;
	logic [2:0]  bitIdx_reg;
	logic [6:0]  shOut_reg;
	logic        so_reg;

	wire        active   = resetN & ~csN;
	wire        sckRise  = sck & ~sckPrev_reg;
	wire        sckFall  = ~sck & sckPrev_reg;
	wire        hdrRise  = active & sckRise & (state_reg == ST_HDR);
	wire [23:0] shiftIn  = {addr_reg[22:0], si};
	wire [7:0]  opIn     = shiftIn[7:0];
	wire [6:0]  opLen    = hdrOf(opIn);
	wire        opIsBuf1 = (opIn == OPC_BUF1_FAST) | (opIn == OPC_BUF1_SLOW);
	wire        opIsBuf2 = (opIn == OPC_BUF2_FAST) | (opIn == OPC_BUF2_SLOW);
	wire        opDone   = hdrRise & (cnt_reg == OPC_LAST_BIT);
	wire        addrDone = hdrRise & (cnt_reg == ADDR_LAST_BIT);
	wire        hdrDone  = hdrRise & (7'(cnt_reg + 7'h01) == hdrLen_reg);
	// Split of the three address bytes
	wire [11:0] pageIn   = pageIs512 ? shiftIn[20:9] : shiftIn[21:10];
	wire [9:0]  byteIn   = pageIs512 ? {1'b0, shiftIn[8:0]}
	                                 : shiftIn[9:0];
	wire [9:0]  byteLast = pageIs512 ? BYTE_LAST_512 : BYTE_LAST_528;
	wire        atLast   = (byte_reg == byteLast);
	wire        fetch    = memReq & memGrant;
	wire        full     = (count_reg == 2'(FIFO_DEPTH));
	wire        empty    = (count_reg == 2'h0);
	wire        push     = memRdValid & memRdReady & fetchEn_reg;
	wire        pop      = active & sckFall & (state_reg == ST_DATA)
	                       & (bitIdx_reg == 3'h0) & ~empty;
	wire [7:0]  headByte = empty ? IDLE_BYTE : fifo_reg[rdPtr_reg];

	// ****************************************
	// Command state
	// ****************************************
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state_reg <= ST_IDLE;
			cnt_reg   <= 7'h00;
			addr_reg  <= 24'h000000;
		end else if (!active) begin
			state_reg <= ST_IDLE;
			cnt_reg   <= 7'h00;
		end else if (state_reg == ST_IDLE) begin
			state_reg <= ST_HDR;
		end else if (hdrRise) begin
			addr_reg <= shiftIn;
			cnt_reg  <= 7'(cnt_reg + 7'h01);
			if (opDone && opLen == HDR_BAD)
				state_reg <= ST_SKIP;
			else if (hdrDone || (addrDone && hdrLen_reg == HDR_NONE))
				state_reg <= ST_DATA;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			sckPrev_reg  <= 1'b0;
			hdrLen_reg   <= HDR_BAD;
			src_reg      <= SEL_ARRAY;
			samePage_reg <= 1'b0;
		end else begin
			sckPrev_reg <= sck;
			if (opDone) begin
				hdrLen_reg   <= opLen;
				src_reg      <= opIsBuf1 ? SEL_BUF1 :
				                opIsBuf2 ? SEL_BUF2 : SEL_ARRAY;
				samePage_reg <= opIsBuf1 | opIsBuf2
				                | (opIn == OPC_PAGE);
			end
		end
	end

	// ****************************************
	// Fetch address counter
	// ****************************************
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			page_reg    <= 12'h000;
			byte_reg    <= 10'h000;
			fetchEn_reg <= 1'b0;
			pend_reg    <= 1'b0;
		end else begin
			if (!active)
				fetchEn_reg <= 1'b0;
			else if (addrDone)
				fetchEn_reg <= 1'b1;
			if (fetch)
				pend_reg <= 1'b1;
			else if (memRdValid)
				pend_reg <= 1'b0;
			if (addrDone) begin
				page_reg <= pageIn;
				byte_reg <= byteIn;
			end else if (fetch) begin
				byte_reg <= atLast ? 10'h000 : 10'(byte_reg + 10'h001);
				if (atLast && !samePage_reg)
					page_reg <= 12'(page_reg + 12'h001);
			end
		end
	end

	// Read-only port: no write path into either buffer exists
	assign memReq     = fetchEn_reg & ~pend_reg & ~full;
	assign memSel     = src_reg;
	assign memPage    = page_reg;
	assign memByte    = byte_reg;
	// Late answers of an ended read are drained and dropped
	assign memRdReady = ~full | ~fetchEn_reg;

	// ****************************************
	// Two-entry data buffer
	// ****************************************
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			wrPtr_reg <= 1'b0;
			rdPtr_reg <= 1'b0;
			count_reg <= 2'h0;
		end else if (!fetchEn_reg) begin
			wrPtr_reg <= 1'b0;
			rdPtr_reg <= 1'b0;
			count_reg <= 2'h0;
		end else begin
			if (push)
				wrPtr_reg <= ~wrPtr_reg;
			if (pop)
				rdPtr_reg <= ~rdPtr_reg;
			count_reg <= 2'(count_reg + {1'b0, push} - {1'b0, pop});
		end
	end

	always_ff @(posedge clock) begin
		if (push)
			fifo_reg[wrPtr_reg] <= memRdData;
	end

	// ****************************************
	// Serial output
	// ****************************************
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			bitIdx_reg <= 3'h0;
			shOut_reg  <= 7'h00;
			so_reg     <= 1'b0;
		end else if (state_reg != ST_DATA) begin
			bitIdx_reg <= 3'h0;
		end else if (sckFall) begin
			bitIdx_reg <= 3'(bitIdx_reg + 3'h1);
			if (bitIdx_reg == 3'h0) begin
				so_reg    <= headByte[7];
				shOut_reg <= headByte[6:0];
			end else begin
				so_reg    <= shOut_reg[6];
				shOut_reg <= {shOut_reg[5:0], 1'b0};
			end
		end
	end

	assign so   = so_reg;
	assign soOe = (state_reg == ST_DATA);

	// ****************************************
	// Checks
	// ****************************************
	csHigh_tristate_a: assert property (@(posedge clock) disable iff (rst)
		csN |=> !soOe)
		else $error("output driven after select went high");

	reset_holds_idle_a: assert property (@(posedge clock) disable iff (rst)
		!resetN |=> state_reg == ST_IDLE && !memReq)
		else $error("sequencer not idle under reset pin");

	legacy_four_dummy_a: assert property (@(posedge clock) disable iff (rst)
		opDone && opIn == OPC_LEGACY |=> hdrLen_reg == HDR_FOUR && !samePage_reg)
		else $error("legacy read header length wrong");

	fast_one_dummy_a: assert property (@(posedge clock) disable iff (rst)
		opDone && opIn == OPC_FAST |=> hdrLen_reg == HDR_ONE && src_reg == SEL_ARRAY)
		else $error("fast read header length wrong");

	slow_no_dummy_a: assert property (@(posedge clock) disable iff (rst)
		addrDone && hdrLen_reg == HDR_NONE |=> state_reg == ST_DATA && memReq)
		else $error("slow read did not start at address end");

	page_read_hdr_a: assert property (@(posedge clock) disable iff (rst)
		opDone && opIn == OPC_PAGE |=> hdrLen_reg == HDR_FOUR && samePage_reg)
		else $error("page read decode wrong");

	buf_select_a: assert property (@(posedge clock) disable iff (rst)
		opDone && (opIn == OPC_BUF2_FAST || opIn == OPC_BUF2_SLOW)
		|=> src_reg == SEL_BUF2 && hdrLen_reg == HDR_ONE)
		else $error("buffer two not selected");

	data_after_hdr_a: assert property (@(posedge clock) disable iff (rst)
		$rose(state_reg == ST_DATA) |-> $past(cnt_reg) == 7'(hdrLen_reg - 7'h01))
		else $error("data phase started at wrong clock");

	next_page_a: assert property (@(posedge clock) disable iff (rst)
		fetch && atLast && !samePage_reg && !addrDone
		|=> memByte == 10'h000 && memPage == 12'($past(memPage) + 12'h001))
		else $error("continuous read did not cross page");

	same_page_a: assert property (@(posedge clock) disable iff (rst)
		fetch && atLast && samePage_reg && !addrDone
		|=> memByte == 10'h000 && $stable(memPage))
		else $error("page or buffer read left its page");

	byte_step_a: assert property (@(posedge clock) disable iff (rst)
		fetch && !atLast && !addrDone
		|=> memByte == 10'($past(memByte) + 10'h001))
		else $error("address counter did not advance");

	array_source_a: assert property (@(posedge clock) disable iff (rst)
		fetch && hdrLen_reg != HDR_ONE |-> memSel == SEL_ARRAY)
		else $error("array read fetched from a buffer");

	array_wrap_a: assert property (@(posedge clock) disable iff (rst)
		fetch && atLast && !samePage_reg && memPage == 12'hfff && !addrDone
		|=> memPage == 12'h000 && memByte == 10'h000)
		else $error("array end did not wrap to first page");

	msb_first_a: assert property (@(posedge clock) disable iff (rst)
		hdrRise
		|=> addr_reg[0] == $past(si) && addr_reg[1] == $past(addr_reg[0]))
		else $error("serial input not shifted in order");

	byte_bound_a: assert property (@(posedge clock) disable iff (rst)
		fetchEn_reg && pageIs512 |-> !memByte[9])
		else $error("byte counter left a 512-byte page");

endmodule : sfr_read_seq

// File: logic/sfr_pkg.sv
// Constants for the serial flash read command sequencer.
// Assumes one system clock; the serial pins are sampled on it.
package sfr_pkg;

	// ****************************************
	// Opcodes
	// ****************************************
	localparam logic [7:0] OPC_LEGACY    = 8'he8;
	localparam logic [7:0] OPC_FAST      = 8'h0b;
	localparam logic [7:0] OPC_SLOW      = 8'h03;
	localparam logic [7:0] OPC_PAGE      = 8'hd2;
	localparam logic [7:0] OPC_BUF1_FAST = 8'hd4;
	localparam logic [7:0] OPC_BUF1_SLOW = 8'hd1;
	localparam logic [7:0] OPC_BUF2_FAST = 8'hd6;
	localparam logic [7:0] OPC_BUF2_SLOW = 8'hd3;

	// ****************************************
	// Header lengths in serial clocks
	// ****************************************
	localparam logic [6:0] OPC_LAST_BIT  = 7'h07;
	localparam logic [6:0] ADDR_LAST_BIT = 7'h1f;
	localparam logic [6:0] HDR_NONE      = 7'h20;
	localparam logic [6:0] HDR_ONE       = 7'h28;
	localparam logic [6:0] HDR_FOUR      = 7'h40;
	localparam logic [6:0] HDR_BAD       = 7'h00;

	// ****************************************
	// Page geometry and memory port selects
	// ****************************************
	localparam logic [9:0] BYTE_LAST_528 = 10'h20f;
	localparam logic [9:0] BYTE_LAST_512 = 10'h1ff;
	localparam logic [1:0] SEL_ARRAY     = 2'h0;
	localparam logic [1:0] SEL_BUF1      = 2'h1;
	localparam logic [1:0] SEL_BUF2      = 2'h2;
	localparam logic [7:0] IDLE_BYTE     = 8'hff;
	localparam int         FIFO_DEPTH    = 2;

	typedef enum logic [1:0] {ST_IDLE, ST_HDR, ST_DATA, ST_SKIP}
		sfr_state_type;

endpackage : sfr_pkg

// File: bench/sfr_mem_model.sv
// Memory model behind the read sequencer's fetch port.
// Assumes one clock; grants when idle (only on alternate clocks when slow), answers after a short latency.
module sfr_mem_model
	import sfr_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        rst,
	input  wire logic        slow,
	input  wire logic        memReq,
	output logic             memGrant,
	input  wire logic [1:0]  memSel,
	input  wire logic [11:0] memPage,
	input  wire logic [9:0]  memByte,
	output logic             memRdValid,
	output logic [7:0]       memRdData,
	input  wire logic        memRdReady
);
	timeunit 1ns;
	timeprecision 1ns;

	logic [1:0] waitCnt;
	logic       busy;
	logic       tick;
	logic [7:0] nextData;
	logic [3:0] pageMix;

	// ****************************************
	// Fetch handling
	// ****************************************
	assign pageMix  = (memSel == SEL_ARRAY) ? memPage[3:0] : 4'h0;
	assign memGrant = memReq && !busy && !memRdValid && (!slow || tick);

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			busy <= 1'b0;
			tick <= 1'b0;
			waitCnt <= 2'h0;
			memRdValid <= 1'b0;
			memRdData <= 8'h00;
			nextData <= 8'h00;
		end else begin
			tick <= !tick;
			if (memGrant) begin
				busy <= 1'b1;
				waitCnt <= slow ? 2'h3 : 2'h0;
				nextData <= memByte[7:0] ^ {pageMix, memSel, memByte[9:8]};
			end else if (busy && waitCnt != 2'h0) begin
				waitCnt <= waitCnt - 2'h1;
			end else if (busy) begin
				busy <= 1'b0;
				memRdValid <= 1'b1;
				memRdData <= nextData;
			end
			// Released data shows the inverse of the last byte
			if (memRdValid && memRdReady) begin
				memRdValid <= 1'b0;
				memRdData <= ~memRdData;
			end
		end
	end
endmodule : sfr_mem_model

// File: bench/serial_flash_read_commands_tb.sv
// Testbench of the read command sequencer.
// Assumes the memory model above; the bench plays the host.
module serial_flash_read_commands_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import sfr_pkg::*;

	logic clock = 1'h0, rst = 1'h1, resetN = 1'h1, csN = 1'h1;
	logic sck = 1'h0, si = 1'h0;
	logic pageIs512 = 1'h0, slow = 1'h0;
	logic so, soOe, memReq, memGrant, memRdValid, memRdReady;
	logic [1:0]  memSel;
	logic [11:0] memPage;
	logic [9:0]  memByte;
	logic [7:0]  memRdData;
	int err_count = 0, total_checks = 0;

	always #10 clock = ~clock;

	sfr_read_seq u_dut (.clock, .rst, .resetN, .csN, .sck, .si, .pageIs512,
		.so, .soOe, .memReq, .memGrant, .memSel, .memPage, .memByte,
		.memRdValid, .memRdData, .memRdReady);
	sfr_mem_model u_mem (.clock, .rst, .slow, .memReq, .memGrant, .memSel,
		.memPage, .memByte, .memRdValid, .memRdData, .memRdReady);

	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic check(input logic [11:0] seen, input logic [11:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	// One serial bit, MSB first; so is sampled before the rise
	task automatic bit_cycle(input logic b, output logic o, output logic oe);
		sck = 0;
		si = b;
		repeat (4) @(negedge clock);
		o = so;
		oe = soOe;
		sck = 1;
		repeat (4) @(negedge clock);
	endtask : bit_cycle

	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx,
		output logic oe);
		for (int i = 7; i >= 0; i--) bit_cycle(tx[i], rx[i], oe);
	endtask : xfer

	task automatic end_cmd();
		sck = 0;
		@(negedge clock);
		csN = 1;
		repeat (2) @(negedge clock);
		check({11'h000, soOe}, 12'h000);
	endtask : end_cmd

	task automatic read_cmd(input logic [7:0] op, input logic [23:0] addr,
		input int nDum, input int n, input logic wrapSame, input logic [1:0] sel);
		logic [11:0] pg;
		logic [9:0]  by;
		logic [9:0]  last;
		logic [7:0]  d;
		logic        oe;
		last = pageIs512 ? BYTE_LAST_512 : BYTE_LAST_528;
		pg = (sel != SEL_ARRAY) ? 12'h000 : pageIs512 ? addr[20:9] : addr[21:10];
		by = pageIs512 ? {1'b0, addr[8:0]} : addr[9:0];
		csN = 0;
		repeat (2) @(negedge clock);
		xfer(op, d, oe);
		for (int k = 0; k < 3 + nDum; k++)
			xfer(k < 3 ? 8'(addr >> (16 - 8 * k)) : 8'h5a, d, oe);
		for (int j = 0; j < n; j++) begin
			xfer(8'h00, d, oe);
			check({4'h0, d}, {4'h0, by[7:0] ^ {pg[3:0], sel, by[9:8]}});
			check({11'h000, oe}, 12'h001);
			if (by == last) begin
				by = 10'h000;
				if (!wrapSame) pg = pg + 12'h001;
			end else begin
				by = by + 10'h001;
			end
		end
		end_cmd();
	endtask : read_cmd

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic scn_array();
		pageIs512 = 0;
		read_cmd(OPC_SLOW, {2'h0, 12'h005, 10'h20e}, 0, 3, 0, SEL_ARRAY);
		read_cmd(OPC_LEGACY, {2'h0, 12'hfff, 10'h20f}, 4, 2, 0, SEL_ARRAY);
		pageIs512 = 1;
		slow = 1;
		read_cmd(OPC_FAST, {3'h0, 12'hfff, 9'h1ff}, 1, 2, 0, SEL_ARRAY);
		read_cmd(OPC_PAGE, {3'h0, 12'h800, 9'h1fe}, 4, 3, 1, SEL_ARRAY);
		slow = 0;
	endtask : scn_array

	task automatic scn_buffers();
		logic [7:0] ops [4] = '{OPC_BUF1_FAST, OPC_BUF1_SLOW, OPC_BUF2_FAST,
			OPC_BUF2_SLOW};
		pageIs512 = 0;
		for (int i = 0; i < 4; i++)
			read_cmd(ops[i], {14'h3fff, 10'h20e}, 1, 3, 1, i < 2 ? SEL_BUF1 : SEL_BUF2);
		pageIs512 = 1;
		read_cmd(OPC_BUF2_FAST, {15'h7fff, 9'h1ff}, 1, 2, 1, SEL_BUF2);
	endtask : scn_buffers

	// Output must stay off: reset pin held low, or unknown opcode
	task automatic scn_idle(input logic [7:0] op, input logic rn);
		logic [7:0] d;
		logic       oe;
		resetN = rn;
		csN = 0;
		repeat (2) @(negedge clock);
		for (int k = 0; k < 5; k++) xfer(k == 0 ? op : 8'h00, d, oe);
		check({11'h000, oe}, 12'h000);
		end_cmd();
		resetN = 1;
		@(negedge clock);
	endtask : scn_idle

	task automatic finish_test();
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : finish_test

	initial begin
		repeat (100000) @(posedge clock);
		err_count++;
		finish_test();
	end

	initial begin
		repeat (12) @(negedge clock);
		rst = 0;
		@(negedge clock);
		scn_array();
		scn_buffers();
		scn_idle(OPC_SLOW, 0);
		scn_idle(8'h00, 1);
		read_cmd(OPC_SLOW, {2'h0, 12'h001, 10'h000}, 0, 1, 0, SEL_ARRAY);
		finish_test();
	end
endmodule : serial_flash_read_commands_tb
